/* logic/addr_decoder.sv */
// prebyte decoder, effective address unit and branch condition logic
//
// Summary of operation
// - long direct takes a 16-bit address from the two following bytes
// - every indexed address is the unsigned sum of index and offset
// - no-offset indexed uses no extra byte, index alone is the address
// - short indexed adds a one-byte offset keeping a 9-bit sum
// - long indexed adds the index to a 16-bit offset
// - short indirect fetches a byte pointer from a zero-page location
// - long indirect forms fetch a word pointer from a byte location
// - indirect indexed adds the index to the fetched pointer
// - short indirect indexed keeps the 9-bit sum up to 1FE
// - relative adds a sign-extended byte offset following the opcode
// - indirect relative fetches the offset from the named location
// - read-modify-write groups decode only to short addressing forms
// - three prebyte codes change the meaning of the next opcode
// - layout is prebyte, opcode, then zero to two address bytes
// - prebyte 90 swaps the first index register for the second
// - prebyte 92 turns direct forms and offset X indexed into indirect ones
// - prebyte 91 turns X indirect indexed into Y indirect indexed
// - bit compare ands accumulator and operand, sets only N and Z
// - bit test branches on selected bit clear or set, bit to carry
// - conditional branches test H, mask level, N, Z, C and unsigned >
// - two branches test the external interrupt pin high or low
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "decoder_regs.svh"
module addr_decoder
  import decoder_pkg::*;
#(
  parameter int AW = 9
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic        ext_int_pin,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  // ************************************************************
  // declarations
  // ************************************************************
  mem_if #(.AW(AW)) mport ();

  insn_t       insn_ff;
  index_t      index_ff;
  cc_t         cc_ff;
  logic [15:0] pc_ff;
  logic [AW-1:0] maddr_ff;
  state_t      st_ff;
  state_t      nxt_st;
  logic [15:0] ptr_ff;
  logic [15:0] ea_ff;
  logic [15:0] npc_ff;
  logic        done_ff;
  logic        pfx_ign_ff;
  logic        taken_ff;
  logic        res_n_ff;
  logic        res_z_ff;
  logic        res_c_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;

  mode_t       mode;
  logic        use_y;
  logic        pfx_ign;
  logic [15:0] ea;
  logic [7:0]  idx;
  logic        need_ptr;
  logic        ptr_word;
  logic        need_opnd;
  logic        is_bit_cmp;
  logic        is_jr;
  logic        is_bitrel;
  logic [7:0]  opnd;
  logic [7:0]  rel_off;
  logic        taken;
  logic        finish;
  logic        apb_setup;
  logic        apb_wr;
  logic        mapped;
  logic        start;

  // ************************************************************
  // helper functions
  // ************************************************************
  // unsigned index addition, never truncated below 16 bits
  function automatic logic [15:0] add_index(input logic [15:0] base,
                                            input logic [7:0]  ix);
    add_index = base + {`BYTE_ZERO, ix};
  endfunction : add_index

  function automatic logic [15:0] sext(input logic [7:0] b);
    sext = {{8{b[7]}}, b};
  endfunction : sext

  function automatic logic [1:0] addr_bytes(input mode_t m);
    case (m)
      MD_INHERENT, MD_IDX_NONE: addr_bytes = 2'h0;
      MD_DIR_LONG, MD_IDX_LONG: addr_bytes = 2'h2;
      MD_BITREL_DIR, MD_BITREL_IND: addr_bytes = 2'h2;
      default: addr_bytes = 2'h1;
    endcase
  endfunction : addr_bytes

  function automatic logic jr_cond(input logic [3:0] lo, input cc_t f,
                                   input logic pin);
    case (br_cond_t'(lo))
      BR_ALWAYS:   jr_cond = 1'b1;
      BR_NEVER:    jr_cond = 1'b0;
      BR_UGT:      jr_cond = ~(f.c | f.z);
      BR_ULE:      jr_cond = f.c | f.z;
      BR_NC:       jr_cond = ~f.c;
      BR_C:        jr_cond = f.c;
      BR_NE:       jr_cond = ~f.z;
      BR_EQ:       jr_cond = f.z;
      BR_NH:       jr_cond = ~f.h;
      BR_H:        jr_cond = f.h;
      BR_PL:       jr_cond = ~f.n;
      BR_MI:       jr_cond = f.n;
      BR_UNMASKED: jr_cond = ~(f.i1 & f.i0);
      BR_MASKED:   jr_cond = f.i1 & f.i0;
      BR_PIN_LOW:  jr_cond = ~pin;
      BR_PIN_HIGH: jr_cond = pin;
      default:     jr_cond = 1'b0;
    endcase
  endfunction : jr_cond

  // ************************************************************
  // prebyte and addressing mode decode
  // ************************************************************
  always_comb
  begin
    logic p90;
    logic p91;
    logic p92;
    logic used;
    p90 = (insn_ff.pre == `PFX_SECOND_INDEX);
    p91 = (insn_ff.pre == `PFX_SECOND_INDIRECT);
    p92 = (insn_ff.pre == `PFX_INDIRECT);
    used = 1'b0;
    use_y = 1'b0;
    mode = MD_INHERENT;
    if (insn_ff.op == `OP_RELATIVE_SUBROUTINE_CALL)
    begin
      mode = p92 ? MD_REL_IND : MD_REL_DIR;
      used = p92;
    end
    else
    begin
      case (op_group_t'(insn_ff.op[7:4]))
        GRP_BTJX:
        begin
          mode = p92 ? MD_BITREL_IND : MD_BITREL_DIR;
          used = p92;
        end
        GRP_BITOP:
        begin
          mode = p92 ? MD_BIT_IND : MD_BIT_DIR;
          used = p92;
        end
        GRP_JR:
        begin
          mode = p92 ? MD_REL_IND : MD_REL_DIR;
          used = p92;
        end
        // read-modify-write groups have no long form at all
        GRP_RMW_DIR:
        begin
          mode = p92 ? MD_IND_SHORT : MD_DIR_SHORT;
          used = p92;
        end
        GRP_RMW_X, GRP_MISC9:
        begin
          mode = MD_INHERENT;
          use_y = p90;
          used = p90;
        end
        GRP_RMW_IDX1, GRP_IDX1:
        begin
          mode = (p92 | p91) ? MD_INDIDX_SHORT : MD_IDX_SHORT;
          use_y = p90 | p91;
          used = p90 | p91 | p92;
        end
        GRP_RMW_IDX0, GRP_IDX0:
        begin
          mode = MD_IDX_NONE;
          use_y = p90;
          used = p90;
        end
        GRP_IMM:
        begin
          mode = MD_IMMEDIATE;
          use_y = p90;
          used = p90;
        end
        GRP_DIR:
        begin
          mode = p92 ? MD_IND_SHORT : MD_DIR_SHORT;
          use_y = p90;
          used = p90 | p92;
        end
        GRP_EXT:
        begin
          mode = p92 ? MD_IND_LONG : MD_DIR_LONG;
          use_y = p90;
          used = p90 | p92;
        end
        GRP_IDX2:
        begin
          mode = (p92 | p91) ? MD_INDIDX_LONG : MD_IDX_LONG;
          use_y = p90 | p91;
          used = p90 | p91 | p92;
        end
        default:
        begin
          mode = MD_INHERENT;
        end
      endcase
    end
    // a prebyte with no modified meaning leaves the opcode as it is
    pfx_ign = (p90 | p91 | p92) & ~used;
  end

  assign idx = use_y ? index_ff.y : index_ff.x;

  assign need_ptr = (mode == MD_IND_SHORT) | (mode == MD_IND_LONG) |
                    (mode == MD_INDIDX_SHORT) | (mode == MD_INDIDX_LONG) |
                    (mode == MD_REL_IND) | (mode == MD_BIT_IND) |
                    (mode == MD_BITREL_IND);
  assign ptr_word = (mode == MD_IND_LONG) | (mode == MD_INDIDX_LONG);
  assign is_jr = (op_group_t'(insn_ff.op[7:4]) == GRP_JR);
  assign is_bitrel = (mode == MD_BITREL_DIR) | (mode == MD_BITREL_IND);
  assign is_bit_cmp = (insn_ff.op[7:4] >= GRP_IMM) & (insn_ff.op[3:0] == `LO_BIT_CMP);
  assign need_opnd = is_bitrel | (is_bit_cmp & (mode != MD_IMMEDIATE));

  // ************************************************************
  // effective address
  // ************************************************************
  always_comb
  begin
    case (mode)
      MD_DIR_SHORT, MD_BIT_DIR, MD_BITREL_DIR: ea = {`BYTE_ZERO, insn_ff.b1};
      MD_DIR_LONG:     ea = {insn_ff.b1, insn_ff.b2};
      MD_IDX_NONE:     ea = {`BYTE_ZERO, idx};
      MD_IDX_SHORT:    ea = add_index({`BYTE_ZERO, insn_ff.b1}, idx);
      MD_IDX_LONG:     ea = add_index({insn_ff.b1, insn_ff.b2}, idx);
      MD_IND_SHORT, MD_BIT_IND, MD_BITREL_IND: ea = ptr_ff;
      MD_IND_LONG:     ea = ptr_ff;
      MD_INDIDX_SHORT: ea = add_index(ptr_ff, idx);
      MD_INDIDX_LONG:  ea = add_index(ptr_ff, idx);
      MD_REL_IND:      ea = {`BYTE_ZERO, insn_ff.b1};
      default:         ea = `ADDR_ZERO;
    endcase
  end

  // ************************************************************
  // sequencer
  // ************************************************************
  assign apb_setup = psel & ~penable;
  assign apb_wr = psel & penable & pready_ff & pwrite;
  assign start = apb_wr & (paddr == `REG_CTRL) & pwdata[`CTRL_START] &
                 (st_ff == ST_IDLE);
  assign finish = ((st_ff == ST_CALC) & ~need_opnd) | (st_ff == ST_OPND);

  always_comb
  begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE:  if (start) nxt_st = need_ptr ? ST_PTR_A : ST_CALC;
      ST_PTR_A: nxt_st = ST_PTR_B;
      ST_PTR_B: nxt_st = ptr_word ? ST_PTR_C : ST_CALC;
      ST_PTR_C: nxt_st = ST_CALC;
      ST_CALC:  nxt_st = need_opnd ? ST_OPND : ST_IDLE;
      ST_OPND:  nxt_st = ST_IDLE;
      default:  nxt_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) st_ff <= ST_IDLE;
    else st_ff <= nxt_st;
  end

  // memory port: the sequencer owns it while busy, the bus otherwise
  always_comb
  begin
    mport.we = 1'b0;
    mport.wdata = pwdata[7:0];
    mport.addr = maddr_ff;
    case (st_ff)
      ST_IDLE: mport.we = apb_wr & (paddr == `REG_MDATA);
      ST_PTR_A: mport.addr = AW'(insn_ff.b1);
      ST_PTR_B: mport.addr = AW'({`BYTE_ZERO, insn_ff.b1} + 16'h0001);
      ST_CALC: mport.addr = ea[AW-1:0];
      default: mport.addr = maddr_ff;
    endcase
  end

  // pointer bytes arrive high byte first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) ptr_ff <= `ADDR_ZERO;
    else if (st_ff == ST_PTR_B) ptr_ff <= {`BYTE_ZERO, mport.rdata};
    else if (st_ff == ST_PTR_C) ptr_ff <= {ptr_ff[7:0], mport.rdata};
  end

  // ************************************************************
  // results: operand, bit compare, branch
  // ************************************************************
  assign opnd = (st_ff == ST_OPND) ? mport.rdata : insn_ff.b1;

  always_comb
  begin
    if (is_bitrel) rel_off = insn_ff.b2;
    else if (mode == MD_REL_IND) rel_off = ptr_ff[7:0];
    else rel_off = insn_ff.b1;
  end

  always_comb
  begin
    if (is_bitrel)
      taken = opnd[insn_ff.op[3:1]] ^ insn_ff.op[0];
    else if (is_jr)
      taken = jr_cond(insn_ff.op[3:0], cc_ff, ext_int_pin);
    else
      taken = (insn_ff.op == `OP_RELATIVE_SUBROUTINE_CALL);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ea_ff <= `ADDR_ZERO;
      npc_ff <= `ADDR_ZERO;
      taken_ff <= 1'b0;
      pfx_ign_ff <= 1'b0;
    end
    else if (finish)
    begin
      ea_ff <= ea;
      npc_ff <= taken ? pc_ff + sext(rel_off) : pc_ff;
      taken_ff <= taken;
      pfx_ign_ff <= pfx_ign;
    end
  end

  // bit compare touches only N and Z; bit test only C
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      res_n_ff <= 1'b0;
      res_z_ff <= 1'b0;
      res_c_ff <= 1'b0;
    end
    else if (finish & is_bit_cmp)
    begin
      res_n_ff <= index_ff.acc[7] & opnd[7];
      res_z_ff <= (index_ff.acc & opnd) == `BYTE_ZERO;
    end
    else if (finish & is_bitrel)
    begin
      res_c_ff <= opnd[insn_ff.op[3:1]];
    end
  end

  // done is cleared by the next start; a finish always wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) done_ff <= 1'b0;
    else if (finish) done_ff <= 1'b1;
    else if (start) done_ff <= 1'b0;
  end

  // ************************************************************
  // software registers
  // ************************************************************
  // instruction and context are locked while a decode runs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      insn_ff <= `WORD_ZERO;
      index_ff <= '0;
      cc_ff <= '0;
      pc_ff <= `ADDR_ZERO;
      maddr_ff <= '0;
    end
    else if (apb_wr & (st_ff == ST_IDLE))
    begin
      case (paddr)
        `REG_INSN:  insn_ff <= pwdata;
        `REG_INDEX: index_ff <= pwdata[23:0];
        `REG_CC:    cc_ff <= pwdata[5:0];
        `REG_PC:    pc_ff <= pwdata[15:0];
        `REG_MADDR: maddr_ff <= pwdata[AW-1:0];
        `REG_MDATA: maddr_ff <= maddr_ff + AW'(1);
        default:    maddr_ff <= maddr_ff;
      endcase
    end
  end

  // ************************************************************
  // bus answer
  // ************************************************************
  always_comb
  begin
    case (paddr)
      `REG_CTRL, `REG_INSN, `REG_INDEX, `REG_CC, `REG_PC, `REG_MADDR,
      `REG_MDATA, `REG_STATUS, `REG_EA, `REG_RESULT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // no wait state: ready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= `WORD_ZERO;
    end
    else if (apb_setup)
    begin
      pready_ff <= 1'b1;
      pslverr_ff <= ~mapped;
      case (paddr)
        `REG_INSN:   prdata_ff <= insn_ff;
        `REG_INDEX:  prdata_ff <= {8'h00, index_ff};
        `REG_CC:     prdata_ff <= {26'h0, cc_ff};
        `REG_PC:     prdata_ff <= {16'h0, pc_ff};
        `REG_MADDR:  prdata_ff <= 32'(maddr_ff);
        `REG_STATUS: prdata_ff <= {16'h0, 4'(mode), 2'h0, addr_bytes(mode),
                                   4'h0, taken_ff, pfx_ign_ff, done_ff,
                                   st_ff != ST_IDLE};
        `REG_EA:     prdata_ff <= {npc_ff, ea_ff};
        `REG_RESULT: prdata_ff <= {29'h0, res_c_ff, res_z_ff, res_n_ff};
        default:     prdata_ff <= `WORD_ZERO;
      endcase
    end
    else
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  ptr_mem #(.AW(AW)) u_mem (
    .pclk (pclk),
    .port (mport.mem)
  );

endmodule : addr_decoder

/* logic/ptr_mem.sv */
// single-port byte memory holding pointers and operands
`timescale 1ns/1ps
module ptr_mem #(
  parameter int AW = 9
) (
  input wire logic pclk,
  mem_if.mem       port
);

  logic [7:0] store [2**AW];
  logic [7:0] rdata_ff;

  // read data is registered: the value of addr is seen one cycle later
  always_ff @(posedge pclk)
  begin
    if (port.we)
    begin
      store[port.addr] <= port.wdata;
    end
    rdata_ff <= store[port.addr];
  end

  assign port.rdata = rdata_ff;

endmodule : ptr_mem

/* shared/decoder_pkg.sv */
// types used by the decoder alone, not by its pointer memory
package decoder_pkg;

  // instruction image as written by software
  typedef struct packed {
    logic [7:0] b2;
    logic [7:0] b1;
    logic [7:0] op;
    logic [7:0] pre;
  } insn_t;

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] y;
    logic [7:0] x;
  } index_t;

  // condition code flags, packed in their usual order
  typedef struct packed {
    logic i1;
    logic h;
    logic i0;
    logic n;
    logic z;
    logic c;
  } cc_t;

  // seventeen modes need five bits; the status field shows only the low four
  typedef enum logic [4:0] {
    MD_INHERENT, MD_IMMEDIATE, MD_DIR_SHORT, MD_DIR_LONG,
    MD_IDX_NONE, MD_IDX_SHORT, MD_IDX_LONG, MD_IND_SHORT,
    MD_IND_LONG, MD_INDIDX_SHORT, MD_INDIDX_LONG, MD_REL_DIR,
    MD_REL_IND, MD_BIT_DIR, MD_BIT_IND, MD_BITREL_DIR, MD_BITREL_IND
  } mode_t;

  // high nibble groups of the opcode map
  typedef enum logic [3:0] {
    GRP_BTJX = 4'h0, GRP_BITOP = 4'h1, GRP_JR = 4'h2, GRP_RMW_DIR = 4'h3,
    GRP_RMW_A = 4'h4, GRP_RMW_X = 4'h5, GRP_RMW_IDX1 = 4'h6,
    GRP_RMW_IDX0 = 4'h7, GRP_MISC8 = 4'h8, GRP_MISC9 = 4'h9,
    GRP_IMM = 4'hA, GRP_DIR = 4'hB, GRP_EXT = 4'hC, GRP_IDX2 = 4'hD,
    GRP_IDX1 = 4'hE, GRP_IDX0 = 4'hF
  } op_group_t;

  // low nibble of the relative branch group
  typedef enum logic [3:0] {
    BR_ALWAYS = 4'h0, BR_NEVER = 4'h1, BR_UGT = 4'h2, BR_ULE = 4'h3,
    BR_NC = 4'h4, BR_C = 4'h5, BR_NE = 4'h6, BR_EQ = 4'h7,
    BR_NH = 4'h8, BR_H = 4'h9, BR_PL = 4'hA, BR_MI = 4'hB,
    BR_UNMASKED = 4'hC, BR_MASKED = 4'hD, BR_PIN_LOW = 4'hE, BR_PIN_HIGH = 4'hF
  } br_cond_t;

  typedef enum {
    ST_IDLE, ST_PTR_A, ST_PTR_B, ST_PTR_C, ST_CALC, ST_OPND
  } state_t;

endpackage : decoder_pkg

/* shared/decoder_regs.svh */
// register offsets, prebyte codes and field positions of the decoder
`ifndef DECODER_REGS_SVH
`define DECODER_REGS_SVH

// byte offsets on the register bus
`define REG_CTRL     8'h00
`define REG_INSN     8'h04
`define REG_INDEX    8'h08
`define REG_CC       8'h0C
`define REG_PC       8'h10
`define REG_MADDR    8'h14
`define REG_MDATA    8'h18
`define REG_STATUS   8'h1C
`define REG_EA       8'h20
`define REG_RESULT   8'h24

// control register fields
`define CTRL_START   0

// prebyte codes
`define PFX_SECOND_INDEX    8'h90
`define PFX_SECOND_INDIRECT 8'h91
`define PFX_INDIRECT        8'h92

// single opcode decoded outside the nibble groups
`define OP_RELATIVE_SUBROUTINE_CALL     8'hAD
// low nibble of the bit compare group
`define LO_BIT_CMP   4'h5

// widths
`define WORD_ZERO    32'h0000_0000
`define BYTE_ZERO    8'h00
`define ADDR_ZERO    16'h0000

`endif

/* shared/mem_if.sv */
// byte-wide port between the decoder and its pointer memory
`timescale 1ns/1ps
interface mem_if #(parameter int AW = 9);
  logic [AW-1:0] addr;
  logic          we;
  logic [7:0]    wdata;
  logic [7:0]    rdata;

  modport ctrl (output addr, output we, output wdata, input rdata);
  modport mem  (input addr, input we, input wdata, output rdata);
endinterface : mem_if

/* testbench/addr_decoder_monitor.sv */
// bus protocol and decode checks on the decoder's register port
`timescale 1ns/1ps
`include "decoder_regs.svh"
module addr_decoder_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        ext_int_pin,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  // ******************************
  // shadow of prebyte and opcode
  // ******************************
  // writes while busy are dropped by the block; the bench only writes when idle
  logic [15:0] insn_ff;
  wire         rd_st = pready && !pwrite && paddr == `REG_STATUS;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      insn_ff <= 16'h0000;
    else if (psel && penable && pready && pwrite && paddr == `REG_INSN)
      insn_ff <= pwdata[15:0];
  // ******************************
  // properties
  // ******************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no answer after setup");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_acc; pready |-> psel && penable; endproperty
  a_acc: assert property (p_acc) else $error("ready outside access");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_unmap; pready && paddr > `REG_RESULT |-> pslverr; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access accepted");
  property p_map; pready && paddr <= `REG_RESULT && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
  a_map: assert property (p_map) else $error("mapped access refused");
  property p_wo; pready && !pwrite && (paddr == `REG_CTRL || paddr == `REG_MDATA)
    |-> prdata == `WORD_ZERO; endproperty
  a_wo: assert property (p_wo) else $error("write-only register read nonzero");
  property p_ext; rd_st && insn_ff[15:12] == 4'hC && insn_ff[7:0] == 8'h00
    |-> prdata[9:8] == 2'h2; endproperty
  a_ext: assert property (p_ext) else $error("long direct length wrong");
  property p_idx0; rd_st && insn_ff[15:12] == 4'hF && insn_ff[7:0] == 8'h00
    |-> prdata[9:8] == 2'h0 && prdata[15:12] == 4'h4; endproperty
  a_idx0: assert property (p_idx0) else $error("no-offset indexed wrong");
  property p_idx1; rd_st && insn_ff[15:12] == 4'hE && insn_ff[7:0] == 8'h00
    |-> prdata[9:8] == 2'h1 && prdata[15:12] == 4'h5; endproperty
  a_idx1: assert property (p_idx1) else $error("short indexed wrong");
  property p_rel; rd_st && insn_ff[15:12] == 4'h2 && insn_ff[7:0] == 8'h00
    |-> prdata[9:8] == 2'h1 && prdata[15:12] == 4'hB; endproperty
  a_rel: assert property (p_rel) else $error("relative direct wrong");
  property p_rmw; rd_st && insn_ff[15:12] inside {4'h3, 4'h6, 4'h7}
    |-> prdata[9:8] != 2'h2; endproperty
  a_rmw: assert property (p_rmw) else $error("long form on read-modify-write");
endmodule : addr_decoder_monitor

bind addr_decoder addr_decoder_monitor addr_decoder_monitor_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .ext_int_pin(ext_int_pin), .prdata(prdata), .pready(pready), .pslverr(pslverr));

/* testbench/apb_host.sv */
// register bus master standing in for the software side
`timescale 1ns/1ps
module apb_host (
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // one transfer; only the bench watchdog ends a wait on a dead slave
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines must not keep looking valid
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : apb_host

/* testbench/tb_top.sv */
// self-checking bench for the address decoder
`timescale 1ns/1ps
`include "decoder_regs.svh"
module tb_top;
  logic        pclk, presetn, ext_int_pin, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr, x, y, b1, b2, m, acc, t;
  logic [31:0] pwdata, prdata, rv, st, ea, res;
  logic [15:0] pc;
  logic [5:0]  cc;
  int          error_cnt, n_checks, seed;
  addr_decoder addr_decoder_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .ext_int_pin, .prdata, .pready, .pslverr);
  apb_host apb_host_i (.pclk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite, .paddr,
    .pwdata);
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // ******************************
  // helpers
  // ******************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb_host_i.xfer(1'b1, a, d, rv, e);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    apb_host_i.xfer(1'b0, a, 32'h0, rv, e);
  endtask : rd
  task automatic poke(input logic [8:0] a, input logic [7:0] d);
    wr(`REG_MADDR, {23'h0, a});
    wr(`REG_MDATA, {24'h0, d});
  endtask : poke
  task automatic go(input logic [31:0] insn);
    int n;
    wr(`REG_INSN, insn);
    wr(`REG_CTRL, 32'h1);
    n = 0;
    do
    begin
      rd(`REG_STATUS);
      n++;
    end while (rv[1:0] !== 2'h2 && n < 20);
    if (rv[1:0] !== 2'h2) error_cnt++;
    st = rv;
    rd(`REG_EA);
    ea = rv;
    rd(`REG_RESULT);
    res = rv;
  endtask : go
  function automatic logic br_exp(input logic [3:0] cd, input logic [5:0] f, input logic p);
    logic tk;
    case (cd[3:1])
      3'h0: tk = 1'b1;
      3'h1: tk = !(f[0] | f[1]);
      3'h2: tk = !f[0];
      3'h3: tk = !f[1];
      3'h4: tk = !f[4];
      3'h5: tk = !f[2];
      3'h6: tk = !(f[5] & f[3]);
      default: tk = !p;
    endcase
    return tk ^ cd[0];
  endfunction : br_exp
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  initial
  begin
    #400000;
    error_cnt++;
    give_verdict;
  end
  // ******************************
  // tests
  // ******************************
  initial
  begin
    seed = 16269;
    error_cnt = 0;
    n_checks = 0;
    ext_int_pin = 1'b0;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`REG_INSN);
    chk("insn reset", rv, 32'h0);
    rd(8'h40);
    chk("unmapped error", {31'h0, e}, 32'h1);
    for (int k = 0; k < 6; k++)
    begin
      x = $random(seed);
      y = $random(seed);
      b1 = $random(seed);
      b2 = $random(seed);
      pc = $random(seed);
      if (k == 0)
      begin
        x = 8'hFF;
        b1 = 8'hFF;
        b2 = 8'h80;
      end
      wr(`REG_INDEX, {16'h0, y, x});
      wr(`REG_PC, {16'h0, pc});
      go({b2, b1, 8'hC6, 8'h00}); chk("long direct", ea[15:0], {b1, b2});
      go({b2, b1, 8'hE6, 8'h00}); chk("short idx", ea[15:0], x + b1);
      go({b2, b1, 8'hF6, 8'h00}); chk("idx none", ea[15:0], x);
      go({b2, b1, 8'hF6, 8'h90}); chk("idx second", ea[15:0], y);
      go({b2, b1, 8'hD6, 8'h00}); chk("long idx", ea[15:0], 16'({b1, b2} + x));
      poke(b1, b2);
      poke(b1 + 9'h001, x);
      go({8'h00, b1, 8'hB6, 8'h92}); chk("ind short", ea[15:0], b2);
      chk("ind mode", st[15:12], 32'h7);
      go({8'h00, b1, 8'hC6, 8'h92}); chk("ind long", ea[15:0], {b2, x});
      go({8'h00, b1, 8'hE6, 8'h92}); chk("ind idx", ea[15:0], b2 + x);
      go({8'h00, b1, 8'hE6, 8'h91}); chk("ind idx y", ea[15:0], b2 + y);
      go({8'h00, b1, 8'h20, 8'h92});
      chk("rel ind", ea[31:16], 16'(pc + {{8{b2[7]}}, b2}));
      go({8'h00, b2, 8'h20, 8'h00});
      chk("rel dir", ea[31:16], 16'(pc + {{8{b2[7]}}, b2}));
    end
    $display("address tests done");
    for (int k = 0; k < 32; k++)
    begin
      cc = $random(seed);
      ext_int_pin <= $random(seed);
      wr(`REG_CC, {26'h0, cc});
      go({16'h0010, 4'h2, 4'(k), 8'h00});
      chk("branch", st[3], br_exp(4'(k), cc, ext_int_pin));
    end
    $display("branch tests done");
    for (int k = 0; k < 16; k++)
    begin
      m = $random(seed);
      b1 = $random(seed);
      poke(b1, m);
      go({8'h05, b1, 8'(k), 8'h00});
      chk("bit carry", res[2], m[k / 2]);
      chk("bit branch", st[3], m[k / 2] ^ k[0]);
    end
    $display("bit test tests done");
    acc = $random(seed);
    m = $random(seed);
    t = acc & m;
    wr(`REG_INDEX, {8'h00, acc, 16'h0000});
    go({8'h00, m, 8'hA5, 8'h00}); chk("bit cmp imm", res[1:0], {t == 8'h00, t[7]});
    poke(9'h033, m);
    go({8'h00, 8'h33, 8'hB5, 8'h00});
    chk("bit cmp mem", res[1:0], {t == 8'h00, t[7]});
    go({8'h00, m, 8'h3C, 8'h00}); chk("rmw mode", st[15:12], 32'h2);
    chk("rmw bytes", st[9:8], 32'h1);
    go({8'h00, m, 8'h3C, 8'h90}); chk("prebyte ignored", st[2], 32'h1);
    chk("prebyte mode", st[15:12], 32'h2);
    $display("misc tests done");
    give_verdict;
  end
endmodule : tb_top
